//--- epwc_assertions.sv
// Pin protocol checks for the EEPROM host controller
module epwc_assertions #(parameter ADDR_W = 17) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Device pins and status
  input wire [ADDR_W-1:0] memAddr_q,
  input wire [7:0] memDataOut_q,
  input wire memDataOe_q,
  input wire busy_q,
  input wire chipSel_n_q,
  input wire outGate_n_q,
  input wire writeStb_n_q,
  input wire hard_protect_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Protect pin only drops with reset, so waits never see it low
  property p_hpUp; !$fell(hard_protect_n); endproperty
  a_hpUp: assert property (p_hpUp) else $error("protect dropped");
  property p_busyHp; busy_q |-> hard_protect_n; endproperty
  a_busyHp: assert property (p_busyHp) else $error("protect low");
  property p_hpIdle; !hard_protect_n |-> chipSel_n_q; endproperty
  a_hpIdle: assert property (p_hpIdle) else $error("select in protect");
  // Strobe lasts 26 cycles with the part selected and the bus steady
  property p_stbLen;
    $fell(writeStb_n_q) |-> ##26 $rose(writeStb_n_q);
  endproperty
  a_stbLen: assert property (p_stbLen) else $error("strobe length");
  property p_wrMode;
    !writeStb_n_q |-> !chipSel_n_q && outGate_n_q && memDataOe_q;
  endproperty
  a_wrMode: assert property (p_wrMode) else $error("write mode pins");
  // No strobe may reach the part while its internal write runs
  property p_busyIdle; busy_q |-> writeStb_n_q && outGate_n_q; endproperty
  a_busyIdle: assert property (p_busyIdle) else $error("strobe in busy");
  property p_hold;
    !$past(writeStb_n_q) && !writeStb_n_q |->
      $stable(memAddr_q) && $stable(memDataOut_q);
  endproperty
  a_hold: assert property (p_hold) else $error("bus moved in strobe");
endmodule // epwc_assertions

//--- epwc_defines.vh
// Constants for the host-side parallel EEPROM page write controller
`ifndef EPWC_DEFINES_VH
`define EPWC_DEFINES_VH
`define EPWC_CLK_NS 10
`define EPWC_BLC_NS 30000
`define EPWC_WC_NS 15000000
`define EPWC_STROBE_NS 250
`define EPWC_SETUP_NS 50
`define EPWC_READ_NS 250
`define EPWC_CMD_A1 17'h05555
`define EPWC_CMD_A2 17'h02aaa
`define EPWC_CMD_D1 8'haa
`define EPWC_CMD_D2 8'h55
`define EPWC_CMD_PROT 8'ha0
`define EPWC_CMD_UNP1 8'h80
`define EPWC_CMD_UNP2 8'h20
`define EPWC_OP_WRITE 2'h0
`define EPWC_OP_PROT 2'h1
`define EPWC_OP_UNPROT 2'h2
`define EPWC_OP_READ 2'h3
`define EPWC_PAGE_MASK 17'h1ff80
`endif

//--- epwc_host.v
// Host controller driving a parallel EEPROM through its pins
`include "epwc_defines.vh"
module epwc_host #(
  parameter ADDR_W = 17,
  parameter PAGE_BYTES = 128,
  parameter BLC_CYC = `EPWC_BLC_NS / `EPWC_CLK_NS,
  parameter WC_CYC = `EPWC_WC_NS / `EPWC_CLK_NS
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Command port: op, address, data
  input wire cmdValid,
  output wire cmdReady,
  input wire [1:0] cmdOp,
  input wire [ADDR_W-1:0] cmdAddr,
  input wire [7:0] cmdData,
  input wire cmdLast,
  // Read result and status
  output wire rdValid,
  input wire rdReady,
  output wire [7:0] rdData,
  output reg busy_q,
  output reg pageErr_q,
  output reg protOn_q,
  // Device pins
  output reg [ADDR_W-1:0] memAddr_q,
  output reg [7:0] memDataOut_q,
  output reg memDataOe_q,
  input wire [7:0] memDataIn,
  output reg chipSel_n_q,
  output reg outGate_n_q,
  output reg writeStb_n_q,
  output reg hard_protect_n,
  input wire readyBusy
);
  localparam STB_CYC = (`EPWC_STROBE_NS + `EPWC_CLK_NS - 1) / `EPWC_CLK_NS;
  localparam SET_CYC = (`EPWC_SETUP_NS + `EPWC_CLK_NS - 1) / `EPWC_CLK_NS;
  localparam RD_CYC = (`EPWC_READ_NS + `EPWC_CLK_NS - 1) / `EPWC_CLK_NS;
  localparam [7:0] S_IDLE = 8'h01, S_SETUP = 8'h02, S_STB = 8'h04,
    S_HOLD = 8'h08, S_POLL = 8'h10, S_RDWAIT = 8'h20, S_RDDONE = 8'h40,
    S_SEQ = 8'h80;
  reg [7:0] state_q;
  reg [23:0] cnt_q;
  reg [23:0] wcCnt_q;
  reg [2:0] seqIdx_q;
  reg [2:0] seqLen_q;
  reg [1:0] op_q;
  reg [ADDR_W-1:0] addr_q;
  reg [7:0] data_q;
  reg last_q;
  reg [7:0] lastByte_q;
  reg [7:0] nBytes_q;
  reg [ADDR_W-1:0] pageBase_q;
  reg inPage_q;
  // Two-entry read buffer
  reg [7:0] buf0_q, buf1_q;
  reg [1:0] bufCnt_q;
  wire bufPush = (state_q == S_RDDONE);
  wire bufPop = rdValid && rdReady;
  assign rdValid = (bufCnt_q != 2'h0);
  assign rdData = buf0_q;
  // Stall commands while a read result could not be buffered
  assign cmdReady = (state_q == S_IDLE) && (bufCnt_q != 2'h2) && !busy_q;
  // Command byte table for protect/unprotect sequences
  reg [ADDR_W-1:0] seqA;
  reg [7:0] seqD;
  always @* begin
    seqA = `EPWC_CMD_A1;
    seqD = `EPWC_CMD_D1;
    case (seqIdx_q)
      3'h1, 3'h4: begin
        seqA = `EPWC_CMD_A2;
        seqD = `EPWC_CMD_D2;
      end
      3'h2: seqD = (op_q == `EPWC_OP_UNPROT) ? `EPWC_CMD_UNP1 :
        `EPWC_CMD_PROT;
      3'h5: seqD = `EPWC_CMD_UNP2;
      default: seqD = (seqIdx_q == 3'h0) ? `EPWC_CMD_D1 : `EPWC_CMD_D1;
    endcase
  end
  // Buffer: pop shifts, push fills first free slot
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      buf0_q <= 8'h00;
      buf1_q <= 8'h00;
      bufCnt_q <= 2'h0;
    end else begin
      if (bufPop) buf0_q <= buf1_q;
      if (bufPush) begin
        if (bufCnt_q == 2'h0 || (bufCnt_q == 2'h1 && bufPop))
          buf0_q <= memDataIn;
        else
          buf1_q <= memDataIn;
      end
      bufCnt_q <= bufCnt_q + {1'b0, bufPush} - {1'b0, bufPop};
    end
  end
  // Main sequencer
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      cnt_q <= 24'h000000;
      wcCnt_q <= 24'h000000;
      seqIdx_q <= 3'h0;
      seqLen_q <= 3'h0;
      op_q <= 2'h0;
      addr_q <= {ADDR_W{1'b0}};
      data_q <= 8'h00;
      last_q <= 1'b0;
      lastByte_q <= 8'h00;
      nBytes_q <= 8'h00;
      pageBase_q <= {ADDR_W{1'b0}};
      inPage_q <= 1'b0;
      busy_q <= 1'b0;
      pageErr_q <= 1'b0;
      protOn_q <= 1'b0;
      memAddr_q <= {ADDR_W{1'b0}};
      memDataOut_q <= 8'h00;
      memDataOe_q <= 1'b0;
      chipSel_n_q <= 1'b1;
      outGate_n_q <= 1'b1;
      writeStb_n_q <= 1'b1;
      hard_protect_n <= 1'b0;
    end else begin
      hard_protect_n <= 1'b1;
      case (state_q)
        S_IDLE: begin
          // Page window open: close it if the next byte is late; a byte
          // taken on the closing edge wins, else busy would stick high
          if (inPage_q && !(cmdValid && cmdReady)) begin
            cnt_q <= cnt_q + 24'h000001;
            if (cnt_q >= BLC_CYC[23:0] - 24'h000001) begin
              inPage_q <= 1'b0;
              busy_q <= 1'b1;
              wcCnt_q <= 24'h000000;
              state_q <= S_POLL;
            end
          end
          if (cmdValid && cmdReady) begin
            op_q <= cmdOp;
            addr_q <= cmdAddr;
            data_q <= cmdData;
            last_q <= cmdLast;
            seqIdx_q <= 3'h0;
            cnt_q <= 24'h000000;
            state_q <= S_SETUP;
            if (cmdOp == `EPWC_OP_WRITE) begin
              // Bytes outside the open page or past 128 are flagged
              pageErr_q <= inPage_q && (((cmdAddr & `EPWC_PAGE_MASK) !=
                pageBase_q) || nBytes_q >= PAGE_BYTES[7:0]);
              if (!inPage_q) begin
                pageBase_q <= cmdAddr & `EPWC_PAGE_MASK;
                nBytes_q <= 8'h00;
              end
              if (protOn_q && !inPage_q) begin
                seqLen_q <= 3'h3;
                state_q <= S_SEQ;
              end else
                seqLen_q <= 3'h0;
            end else if (cmdOp == `EPWC_OP_PROT) begin
              seqLen_q <= 3'h3;
              state_q <= S_SEQ;
            end else if (cmdOp == `EPWC_OP_UNPROT) begin
              seqLen_q <= 3'h6;
              state_q <= S_SEQ;
            end
          end
        end
        S_SEQ: begin
          // Present one command byte, then strobe it
          memAddr_q <= seqA;
          memDataOut_q <= seqD;
          memDataOe_q <= 1'b1;
          cnt_q <= 24'h000000;
          state_q <= S_SETUP;
        end
        S_SETUP: begin
          if (seqIdx_q == seqLen_q) begin
            memAddr_q <= addr_q;
            memDataOut_q <= data_q;
            memDataOe_q <= (op_q != `EPWC_OP_READ);
          end
          chipSel_n_q <= 1'b0;
          cnt_q <= cnt_q + 24'h000001;
          if (cnt_q >= SET_CYC[23:0]) begin
            cnt_q <= 24'h000000;
            if (op_q == `EPWC_OP_READ)
              outGate_n_q <= 1'b0;
            else
              writeStb_n_q <= 1'b0;
            state_q <= (op_q == `EPWC_OP_READ) ? S_RDWAIT : S_STB;
          end
        end
        S_STB: begin
          cnt_q <= cnt_q + 24'h000001;
          if (cnt_q >= STB_CYC[23:0]) begin
            writeStb_n_q <= 1'b1;
            cnt_q <= 24'h000000;
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          // Release strobes; idle time exceeds the 20 ns filter
          chipSel_n_q <= 1'b1;
          memDataOe_q <= 1'b0;
          cnt_q <= 24'h000000;
          if (seqIdx_q != seqLen_q) begin
            seqIdx_q <= seqIdx_q + 3'h1;
            state_q <= (seqIdx_q + 3'h1 == seqLen_q) &&
              (op_q != `EPWC_OP_WRITE) ? S_POLL : S_SEQ;
            if ((seqIdx_q + 3'h1 == seqLen_q) &&
                (op_q == `EPWC_OP_WRITE))
              state_q <= S_SETUP;
            if ((seqIdx_q + 3'h1 == seqLen_q) &&
                (op_q != `EPWC_OP_WRITE)) begin
              protOn_q <= (op_q == `EPWC_OP_PROT);
              busy_q <= 1'b1;
              wcCnt_q <= 24'h000000;
            end
          end else begin
            lastByte_q <= data_q;
            nBytes_q <= nBytes_q + 8'h01;
            inPage_q <= !last_q;
            if (last_q) begin
              // Hold strobes idle; device self-starts after 30 us
              busy_q <= 1'b1;
              wcCnt_q <= 24'h000000;
              state_q <= S_POLL;
            end else
              state_q <= S_IDLE;
          end
        end
        S_POLL: begin
          // Wait out the write; ready/busy floats high once done
          wcCnt_q <= wcCnt_q + 24'h000001;
          if ((wcCnt_q > BLC_CYC[23:0] && readyBusy) ||
              wcCnt_q >= WC_CYC[23:0]) begin
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_RDWAIT: begin
          cnt_q <= cnt_q + 24'h000001;
          if (cnt_q >= RD_CYC[23:0])
            state_q <= S_RDDONE;
        end
        S_RDDONE: begin
          outGate_n_q <= 1'b1;
          chipSel_n_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // epwc_host

//--- epwc_mem_model.sv
// Behavioural paged parallel EEPROM on the far side of the pins
module epwc_mem_model #(parameter IDLE_NS = 600, parameter WC_NS = 3000) (
  // Device pins
  input wire [16:0] addr,
  input wire [7:0] wrData,
  output wire [7:0] dataOut,
  input wire chipSel_n,
  input wire outGate_n,
  input wire writeStb_n,
  input wire hard_protect_n,
  output wire readyBusy
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [68:0] ENA = {15'h5555, 8'haa, 15'h2aaa, 8'h55,
    15'h5555, 8'ha0};
  localparam logic [137:0] DIS = {15'h5555, 8'haa, 15'h2aaa, 8'h55,
    15'h5555, 8'h80, ENA[68:8], 8'h20};
  logic [7:0] mem [0:131071];
  logic [7:0] pg [0:127];
  logic [7:0] rv, lastD, held = 8'h00;
  logic [127:0] pgVld = 0;
  logic [137:0] hv;
  logic [16:0] aLat, pgBase;
  logic armed = 0, busy = 0, prot = 0, open = 0, rbLow = 0;
  realtime tFall;
  int gen;
  wire rdEn = !chipSel_n && !outGate_n && writeStb_n && hard_protect_n;
  // Array starts erased
  initial foreach (mem[i]) mem[i] = 8'hff;
  // Address on the edge completing selection; refused while busy
  always @(negedge writeStb_n or negedge chipSel_n)
    if (!writeStb_n && !chipSel_n && outGate_n && hard_protect_n && !busy)
    begin
      aLat = addr;
      tFall = $realtime;
      armed = 1;
    end
  // Data on the ending edge; pulses of 20 ns or less are noise
  always @(posedge writeStb_n or posedge chipSel_n) begin
    if (armed && $realtime - tFall > 20) load(wrData);
    armed = 0;
  end
  task automatic load(input logic [7:0] d);
    hv = {hv[114:0], aLat[14:0], d};
    if (pgVld == 0) pgBase = aLat;
    pg[aLat[6:0]] = d;
    pgVld[aLat[6:0]] = 1;
    {lastD, rbLow} = {d, 1'b1};
    if (hv[68:0] == ENA) {pgVld, prot, open} = {128'h0, 2'h3};
    if (hv == DIS) {pgVld, prot} = 0;
    gen++;
    fork commit(gen); join_none
  endtask
  // Idle window, then erase and write; a later byte restarts it
  task automatic commit(input int g);
    #(IDLE_NS);
    if (g != gen) return;
    busy = 1;
    #(WC_NS);
    if (!prot || open) foreach (pgVld[i])
      if (pgVld[i]) mem[{pgBase[16:7], 7'(i)}] = pg[i];
    {pgVld, open, busy, rbLow} = 0;
  endtask
  // Protect falling aborts the pending page
  always @(negedge hard_protect_n) pgVld = 0;
  // Polling shows inverted bit 7; a released bus shows the inverse
  assign rv = rbLow ? {~lastD[7], 7'h00} : mem[addr];
  always @(negedge rdEn) held = rv;
  assign dataOut = rdEn ? rv : ~held;
  assign readyBusy = rbLow ? 1'b0 : 1'bz;
endmodule // epwc_mem_model

//--- test_epwc_host.sv
// Self-checking bench for the EEPROM host controller
module test_epwc_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, rst_b = 0, cmdValid = 0, cmdLast = 0, rdReady = 0;
  logic [1:0] cmdOp = 0;
  logic [16:0] cmdAddr = 0;
  logic [7:0] cmdData = 0;
  wire cmdReady, rdValid, chipSel_n_q, outGate_n_q, writeStb_n_q;
  wire hard_protect_n;
  wire busy_q, pageErr_q, protOn_q;
  wire [7:0] rdData, memDataOut_q, memDataIn;
  wire [16:0] memAddr_q;
  tri1 readyBusy;
  int errors, samples_checked;
  // Rows: op, address, data, last, expected read data
  logic [35:0] rows [12] = '{
    {2'h0,17'h10005,8'h3c,1'b0,8'h0}, {2'h0,17'h10003,8'hc5,1'b1,8'h0},
    {2'h3,17'h10005,8'h00,1'b0,8'h3c}, {2'h3,17'h10003,8'h0,1'b0,8'hc5},
    {2'h1,17'h00000,8'h00,1'b1,8'h0}, {2'h0,17'h10100,8'h81,1'b1,8'h0},
    {2'h3,17'h10100,8'h00,1'b0,8'h81}, {2'h2,17'h0,8'h00,1'b1,8'h0},
    {2'h0,17'h10200,8'h7e,1'b1,8'h0}, {2'h3,17'h10200,8'h0,1'b0,8'h7e},
    {2'h3,17'h05555,8'h00,1'b0,8'hff}, {2'h3,17'h02aaa,8'h0,1'b0,8'hff}};
  epwc_host #(.BLC_CYC(50), .WC_CYC(2000)) epwc_host_i (.mclk, .rst_b,
    .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdData, .cmdLast, .rdValid,
    .rdReady, .rdData, .busy_q, .pageErr_q, .protOn_q, .memAddr_q,
    .memDataOut_q, .memDataOe_q(), .memDataIn, .chipSel_n_q, .outGate_n_q,
    .writeStb_n_q, .hard_protect_n, .readyBusy);
  epwc_mem_model epwc_mem_model_i (.addr(memAddr_q), .wrData(memDataOut_q),
    .dataOut(memDataIn), .chipSel_n(chipSel_n_q), .outGate_n(outGate_n_q),
    .writeStb_n(writeStb_n_q), .hard_protect_n, .readyBusy);
  // 100 MHz clock
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A bound that runs out ends the run
  task automatic late;
    errors++;
    $display("MISMATCH %0t no handshake", $time);
    complete_run;
  endtask
  task automatic send(input logic [35:0] r);
    logic ok;
    int n;
    {cmdOp, cmdAddr, cmdData, cmdLast} = r[35:8];
    cmdValid = 1;
    for (n = 0; n < 9000; n++) begin
      #4 ok = cmdReady;
      @(posedge mclk) #1;
      if (ok === 1'b1) break;
    end
    cmdValid = 0;
    if (n == 9000) late;
    @(posedge mclk) #1;
  endtask
  task automatic get(input logic [7:0] e);
    logic ok;
    logic [7:0] v;
    int n;
    for (n = 0; n < 9000; n++) begin
      #4 ok = rdValid;
      v = rdData;
      @(posedge mclk) #1;
      if (ok === 1'b1) break;
    end
    if (n == 9000) late;
    chk(v, e);
  endtask
  // Reset, table rows, full page, a stalled read buffer, then the page window
  initial begin
    repeat (8) @(posedge mclk);
    #1 chk(8'(hard_protect_n), 8'h0);
    rst_b = 1;
    rdReady = 1;
    @(posedge mclk) #1 chk(8'(hard_protect_n), 8'h1);
    $display("test reset done");
    foreach (rows[i]) begin
      send(rows[i]);
      chk(8'(protOn_q), 8'(i >= 5 && i <= 7));
      if (rows[i][35:34] == 2'h3) get(rows[i][7:0]);
    end
    $display("test rows done");
    for (int i = 0; i < 128; i++)
      send({2'h0, 10'h3, ~i[6:0], i[7:0] ^ 8'h5a, i == 127, 8'h0});
    #400 chk(8'(busy_q), 8'h1);
    rdReady = 0;
    send({2'h3, 17'h001ff, 17'h0});
    send({2'h3, 17'h00180, 17'h0});
    #800 chk(8'(cmdReady), 8'h0);
    rdReady = 1;
    get(8'h5a);
    get(8'h25);
    $display("test page and buffer done");
    // Page left open: a stray byte is flagged, then the window closes it
    send({2'h0, 17'h00400, 8'h11, 1'b0, 8'h0});
    chk(8'(pageErr_q), 8'h0);
    send({2'h0, 17'h00500, 8'h22, 1'b0, 8'h0});
    chk(8'(pageErr_q), 8'h1);
    #1000 chk(8'(busy_q), 8'h1);
    send({2'h3, 17'h00400, 17'h0});
    get(8'h22);
    $display("test page window done");
    complete_run;
  end
endmodule // test_epwc_host
bind epwc_host epwc_assertions #(.ADDR_W(ADDR_W)) epwc_assertions_i (.mclk,
  .rst_b, .memAddr_q, .memDataOut_q, .memDataOe_q, .busy_q, .chipSel_n_q,
  .outGate_n_q, .writeStb_n_q, .hard_protect_n);
